// ==== rtl/vco_prbs_defs.svh ====
`ifndef VCO_PRBS_DEFS_SVH
`define VCO_PRBS_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_VCO_CAP_COUNT      8'h08
`define OFS_CHANNEL_OVERRIDE   8'h09
`define OFS_PATTERN_CLOCK_EN   8'h0d
`define OFS_SIGNAL_DETECT      8'h14
`define OFS_VCO_DIVIDER_SEL    8'h18
`define OFS_CHARGE_PUMP        8'h1b
`define OFS_OUTPUT_SELECT      8'h1e
`define OFS_LOOP_FILTER_DAC    8'h1f
`define OFS_PATTERN_CONTROL    8'h30

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define OVR_DIV_BIT            2
`define OVR_CP_BIT             3
`define OVR_QCLK_BIT           4
`define OVR_MUX_BIT            5
`define OVR_LFDAC_BIT          6
`define OVR_CAP_BIT            7
`define PCLK_RUN_BIT           5
`define PG_LOGIC_EN_BIT        4
`define OSEL_QCLK_BIT          0
`define PCLK_LOAD_BIT          3
`define SD_FORCE_ON_BIT        7
`define SD_FORCE_OFF_BIT       6

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_OVERRIDE           8'h00
`define RST_OUTPUT_SELECT      8'he0
`define RST_PLAIN              8'h00

// ----------------------------------------------------------------------
// encodings
// ----------------------------------------------------------------------
`define MUX_RAW                3'h0
`define MUX_RETIMED            3'h1
`define MUX_ICLK               3'h2
`define MUX_QCLK               3'h3
`define MUX_PRBS               3'h4
`define MUX_CLK10M             3'h5
`define MUX_MUTE               3'h7
`define DIV_CODE_MAX           3'h4
`define SEQ_PRBS9              2'h0
`define SEQ_PRBS31             2'h2

`endif

// ==== rtl/vco_prbs_pkg.sv ====
package vco_prbs_pkg;

  // ----------------------------------------------------------------------
  // shared types
  // ----------------------------------------------------------------------
  typedef logic [7:0] reg_byte_t;   // one byte register
  typedef logic [2:0] div_code_t;   // divider select code
  typedef logic [2:0] mux_code_t;   // output source code

  // pattern generator states
  typedef enum logic [1:0] {
    PG_IDLE,
    PG_HOLD,
    PG_LOADED,
    PG_RUN
  } pg_state_t;

endpackage

// ==== rtl/prbs_gen.sv ====
`timescale 1ns/1ns
`include "vco_prbs_defs.svh"

module prbs_gen
  import vco_prbs_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // control levels
  input  wire logic       logic_en_i,
  input  wire logic       clk_load_i,
  input  wire logic       clk_run_i,
  input  wire logic [1:0] seq_sel_i,
  // pattern out
  output logic            prbs_bit_o,
  output logic            running_o
);

  // ----------------------------------------------------------------------
  // state and shift register
  // ----------------------------------------------------------------------
  pg_state_t   state_q;     // generator state
  pg_state_t   state_d;     // next state
  logic [30:0] lfsr_q;      // shared shift register
  logic        long_q;      // latched sequence type, 1 = 31-bit
  logic        fb;          // feedback tap result

  // x^9+x^5+1 or x^31+x^28+1
  assign fb = long_q ? (lfsr_q[30] ^ lfsr_q[27]) : (lfsr_q[8] ^ lfsr_q[4]);

  // next state from the three control levels
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      PG_IDLE:   state_d = PG_HOLD;
      PG_HOLD:   state_d = clk_load_i ? PG_LOADED : PG_HOLD;
      PG_LOADED: state_d = clk_run_i ? PG_RUN : PG_LOADED;
      PG_RUN:    state_d = clk_run_i ? PG_RUN : PG_LOADED;
    endcase
    if (!logic_en_i)
      state_d = PG_IDLE;           // logic off stays inactive
    else if (!clk_load_i)
      state_d = PG_HOLD;           // clear load bit holds reset
  end

  // state, seed and shift
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_q    <= PG_IDLE;
      lfsr_q     <= '1;
      long_q     <= 1'b0;
      prbs_bit_o <= 1'b0;
      running_o  <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      running_o <= (state_d == PG_RUN);
      if (state_q == PG_HOLD || state_q == PG_IDLE)
      begin
        lfsr_q     <= '1;                  // seed while clock in reset
        long_q     <= seq_sel_i[1];        // 0x0 short, 0x2 long
        prbs_bit_o <= 1'b0;
      end
      else if (state_q == PG_RUN)
      begin
        lfsr_q     <= {lfsr_q[29:0], fb};  // advance only when clock runs
        prbs_bit_o <= fb;
      end
    end
  end

endmodule

// ==== rtl/vco_override_prbs_control.sv ====
//
// Contract
// - auto divider ratio 1,2,4,8,16 from rate
// - override bit 2 takes divider field
// - divider codes 0..4 only, ratio 2^code
// - sequence 0x0 short, 0x2 long pattern
// - output-select bit 4 enables generator logic
// - load bit clear resets, set loads clock
// - clock enable bit 5 starts generator
// - mux override plus code 4 sends pattern while channel powered
// - VCO tracking independent of output mux
// - force detect bit 7 with bit 6 clear enables idle channel
// - override bit 3, field 0 stops pump
// - override bit 7 uses capacitor count
// - override bit 6 enables filter DAC
// - override register resets and clears 0x00
// - mux override outputs selected source while channel powered, else mutes
//
`timescale 1ns/1ns
`include "vco_prbs_defs.svh"

module vco_override_prbs_control
  import vco_prbs_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // byte register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_rvalid_o,
  // channel status from pins
  input  wire logic       sig_detect_i,
  input  wire logic       cdr_locked_i,
  input  wire logic       clk10m_i,
  // channel logic on this clock
  input  wire logic [2:0] auto_div_code_i,
  input  wire logic       retimed_bit_i,
  input  wire logic       raw_bit_i,
  input  wire logic       vco_iclk_i,
  input  wire logic       vco_qclk_i,
  // vco controls
  output logic      [2:0] div_code_o,
  output logic      [4:0] div_ratio_o,
  output logic            cap_ovr_o,
  output logic      [4:0] cap_count_o,
  output logic            lfdac_en_o,
  output logic      [4:0] lfdac_value_o,
  output logic            cp_enable_o,
  output logic            vco_track_o,
  // channel and output
  output logic            channel_en_o,
  output logic            tx_bit_o,
  output logic            tx_mute_o,
  output logic            prbs_active_o
);

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------

  // true when the register port addresses the given offset
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // only codes 0 to 4 name a divider
  function automatic logic div_ok(input div_code_t code);
    div_ok = (code <= `DIV_CODE_MAX);
  endfunction

  // code n divides by two to the n
  function automatic logic [4:0] div_ratio(input div_code_t code);
    div_ratio = 5'h01 << code;
  endfunction

  // ----------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------
  reg_byte_t cap_q;         // capacitor count
  reg_byte_t ovr_q;         // channel override enables
  reg_byte_t pclk_q;        // pattern clock enable
  reg_byte_t sdf_q;         // signal detect force
  reg_byte_t divsel_q;      // divider select
  reg_byte_t cp_q;          // charge pump control
  reg_byte_t osel_q;        // output select and generator enable
  reg_byte_t lfd_q;         // loop filter dac value
  reg_byte_t pctl_q;        // pattern control

  // ----------------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------------
  logic wr_cap;             // write to capacitor count
  logic wr_ovr;             // write to override enables
  logic wr_pclk;            // write to pattern clock enable
  logic wr_sdf;             // write to signal detect force
  logic wr_div;             // write to divider select
  logic wr_cp;              // write to charge pump
  logic wr_osel;            // write to output select
  logic wr_lfd;             // write to filter dac
  logic wr_pctl;            // write to pattern control

  assign wr_cap  = reg_wr_i & hit(reg_addr_i, `OFS_VCO_CAP_COUNT);
  assign wr_ovr  = reg_wr_i & hit(reg_addr_i, `OFS_CHANNEL_OVERRIDE);
  assign wr_pclk = reg_wr_i & hit(reg_addr_i, `OFS_PATTERN_CLOCK_EN);
  assign wr_sdf  = reg_wr_i & hit(reg_addr_i, `OFS_SIGNAL_DETECT);
  assign wr_div  = reg_wr_i & hit(reg_addr_i, `OFS_VCO_DIVIDER_SEL);
  assign wr_cp   = reg_wr_i & hit(reg_addr_i, `OFS_CHARGE_PUMP);
  assign wr_osel = reg_wr_i & hit(reg_addr_i, `OFS_OUTPUT_SELECT);
  assign wr_lfd  = reg_wr_i & hit(reg_addr_i, `OFS_LOOP_FILTER_DAC);
  assign wr_pctl = reg_wr_i & hit(reg_addr_i, `OFS_PATTERN_CONTROL);

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------

  // override enables: whole byte replaced, 0x00 clears all
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      ovr_q <= `RST_OVERRIDE;
    else if (wr_ovr)
      ovr_q <= reg_wdata_i;
  end

  // output select: mute code after reset
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      osel_q <= `RST_OUTPUT_SELECT;
    else if (wr_osel)
      osel_q <= reg_wdata_i;
  end

  // vco setup registers
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cap_q    <= `RST_PLAIN;
      divsel_q <= `RST_PLAIN;
      cp_q     <= `RST_PLAIN;
      lfd_q    <= `RST_PLAIN;
    end
    else
    begin
      if (wr_cap)
        cap_q <= reg_wdata_i;
      if (wr_div)
        divsel_q <= reg_wdata_i;
      if (wr_cp)
        cp_q <= reg_wdata_i;
      if (wr_lfd)
        lfd_q <= reg_wdata_i;
    end
  end

  // channel and generator setup registers
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pclk_q <= `RST_PLAIN;
      sdf_q  <= `RST_PLAIN;
      pctl_q <= `RST_PLAIN;
    end
    else
    begin
      if (wr_pclk)
        pclk_q <= reg_wdata_i;
      if (wr_sdf)
        sdf_q <= reg_wdata_i;
      if (wr_pctl)
        pctl_q <= reg_wdata_i;
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  reg_byte_t rd_mux;        // selected read byte, unmapped reads zero

  assign rd_mux =
    hit(reg_addr_i, `OFS_VCO_CAP_COUNT)    ? cap_q    :
    hit(reg_addr_i, `OFS_CHANNEL_OVERRIDE) ? ovr_q    :
    hit(reg_addr_i, `OFS_PATTERN_CLOCK_EN) ? pclk_q   :
    hit(reg_addr_i, `OFS_SIGNAL_DETECT)    ? sdf_q    :
    hit(reg_addr_i, `OFS_VCO_DIVIDER_SEL)  ? divsel_q :
    hit(reg_addr_i, `OFS_CHARGE_PUMP)      ? cp_q     :
    hit(reg_addr_i, `OFS_OUTPUT_SELECT)    ? osel_q   :
    hit(reg_addr_i, `OFS_LOOP_FILTER_DAC)  ? lfd_q    :
    hit(reg_addr_i, `OFS_PATTERN_CONTROL)  ? pctl_q   : 8'h00;

  // read data answers one cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
        reg_rdata_o <= rd_mux;
    end
  end

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] sd_sync_q;    // signal detect, two stages
  logic [1:0] lk_sync_q;    // cdr lock, two stages
  logic [1:0] ck_sync_q;    // slow internal clock, two stages
  logic       sd_s;         // synchronised signal detect
  logic       lk_s;         // synchronised lock
  logic       ck_s;         // synchronised slow clock

  // only the second stage is read below
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sd_sync_q <= 2'h0;
      lk_sync_q <= 2'h0;
      ck_sync_q <= 2'h0;
    end
    else
    begin
      sd_sync_q <= {sd_sync_q[0], sig_detect_i};
      lk_sync_q <= {lk_sync_q[0], cdr_locked_i};
      ck_sync_q <= {ck_sync_q[0], clk10m_i};
    end
  end

  assign sd_s = sd_sync_q[1];
  assign lk_s = lk_sync_q[1];
  assign ck_s = ck_sync_q[1];

  // ----------------------------------------------------------------------
  // channel enable and vco controls
  // ----------------------------------------------------------------------
  logic      force_on;      // detect forced active
  logic      force_off;     // detect forced inactive
  logic      chan_en;       // channel powered
  logic      pump_off;      // charge pump disabled
  div_code_t div_cand;      // candidate divider code

  // bit 7 set, bit 6 clear forces detect on
  assign force_on  = sdf_q[`SD_FORCE_ON_BIT] & ~sdf_q[`SD_FORCE_OFF_BIT];
  assign force_off = sdf_q[`SD_FORCE_OFF_BIT];
  // without a signal the channel powers down by default
  assign chan_en   = force_on | (sd_s & ~force_off);

  // override bit 3 with pump field zero lets the vco free-run
  assign pump_off  = ovr_q[`OVR_CP_BIT] & (cp_q[1:0] == 2'h0);

  // override bit 2 picks the register field, else automatic
  assign div_cand  = ovr_q[`OVR_DIV_BIT] ? divsel_q[6:4] : auto_div_code_i;

  // divider: invalid codes leave the last valid ratio in place
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      div_code_o  <= 3'h0;
      div_ratio_o <= 5'h01;
    end
    else if (div_ok(div_cand))
    begin
      div_code_o  <= div_cand;
      div_ratio_o <= div_ratio(div_cand);
    end
  end

  // analog overrides and loop state
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cap_ovr_o     <= 1'b0;
      cap_count_o   <= 5'h00;
      lfdac_en_o    <= 1'b0;
      lfdac_value_o <= 5'h00;
      cp_enable_o   <= 1'b1;
      vco_track_o   <= 1'b0;
      channel_en_o  <= 1'b0;
    end
    else
    begin
      cap_ovr_o     <= ovr_q[`OVR_CAP_BIT];
      cap_count_o   <= cap_q[4:0];
      lfdac_en_o    <= ovr_q[`OVR_LFDAC_BIT];
      lfdac_value_o <= lfd_q[4:0];
      cp_enable_o   <= ~pump_off;
      // tracking follows lock, channel enable and pump only, never the mux
      vco_track_o   <= lk_s & chan_en & ~pump_off;
      channel_en_o  <= chan_en;
    end
  end

  // ----------------------------------------------------------------------
  // pattern generator
  // ----------------------------------------------------------------------
  logic pg_bit;             // generator serial bit
  logic pg_run;             // generator clock running

  // enable, load and run levels come straight from registers
  prbs_gen u_prbs_gen (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .logic_en_i (osel_q[`PG_LOGIC_EN_BIT]),
    .clk_load_i (pctl_q[`PCLK_LOAD_BIT]),
    .clk_run_i  (pclk_q[`PCLK_RUN_BIT]),
    .seq_sel_i  (pctl_q[1:0]),
    .prbs_bit_o (pg_bit),
    .running_o  (pg_run)
  );

  // ----------------------------------------------------------------------
  // output multiplexer
  // ----------------------------------------------------------------------
  mux_code_t sel_eff;       // source actually driven
  logic      qclk_ok;       // quadrature clock enabled
  logic      src_bit;       // bit of the selected source
  logic      src_mute;      // selected source mutes the driver

  // override drives the field, else lock and detect decide
  assign sel_eff = ovr_q[`OVR_MUX_BIT] ? osel_q[7:5] :
                   ~chan_en            ? `MUX_MUTE   :
                   lk_s                ? `MUX_RETIMED : osel_q[7:5];

  // quadrature clock needs two enables
  assign qclk_ok = ovr_q[`OVR_QCLK_BIT] & osel_q[`OSEL_QCLK_BIT];

  // source data per code
  always_comb
  begin
    src_bit  = 1'b0;
    src_mute = 1'b0;
    unique case (sel_eff)
      `MUX_RAW:     src_bit = raw_bit_i;
      `MUX_RETIMED: src_bit = retimed_bit_i;
      `MUX_ICLK:    src_bit = vco_iclk_i;
      `MUX_QCLK:
      begin
        src_bit  = vco_qclk_i;
        src_mute = ~qclk_ok;
      end
      `MUX_PRBS:
      begin
        src_bit  = pg_bit;
        src_mute = ~pg_run;
      end
      `MUX_CLK10M:  src_bit = ck_s;
      default:      src_mute = 1'b1;          // mute and the invalid code
    endcase
  end

  // registered line driver controls
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      tx_bit_o      <= 1'b0;
      tx_mute_o     <= 1'b1;
      prbs_active_o <= 1'b0;
    end
    else
    begin
      // a powered-down channel mutes too, so the data bit must drop with it
      tx_bit_o      <= src_bit & ~src_mute & chan_en;
      tx_mute_o     <= src_mute | ~chan_en;
      prbs_active_o <= pg_run & (sel_eff == `MUX_PRBS) & chan_en;
    end
  end

endmodule

// ==== bench/vco_prbs_checker.sv ====
`timescale 1ns/1ns
module vco_prbs_checker (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  // watched ports
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic [2:0] auto_div_code_i,
  input wire logic [2:0] div_code_o,
  input wire logic [4:0] div_ratio_o,
  input wire logic       cap_ovr_o,
  input wire logic [4:0] cap_count_o,
  input wire logic       lfdac_en_o,
  input wire logic [4:0] lfdac_value_o,
  input wire logic       cp_enable_o,
  input wire logic       tx_bit_o,
  input wire logic       tx_mute_o,
  input wire logic       prbs_active_o
);
  // ----------------------------------------------------------------
  // shadow copies of written fields
  // ----------------------------------------------------------------
  logic [7:0] ovr_q;  // override enables
  logic [2:0] div_q;  // divider field
  logic [1:0] cp_q;   // pump field
  logic [4:0] cap_q;  // capacitor count
  logic [4:0] lf_q;   // filter dac value

  // follow every write, cleared with the design
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ovr_q <= 8'h00;
      div_q <= 3'h0;
      cp_q  <= 2'h0;
      cap_q <= 5'h00;
      lf_q  <= 5'h00;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        8'h09:   ovr_q <= reg_wdata_i;
        8'h18:   div_q <= reg_wdata_i[6:4];
        8'h1b:   cp_q  <= reg_wdata_i[1:0];
        8'h08:   cap_q <= reg_wdata_i[4:0];
        8'h1f:   lf_q  <= reg_wdata_i[4:0];
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_div_auto: assert property (
    !$past(sys_rst_i) && !ovr_q[2] && $stable(ovr_q) && $stable(auto_div_code_i)
    && auto_div_code_i <= 3'h4 |-> div_code_o == auto_div_code_i)
    else $error("automatic divider code not followed");
  chk_div_override: assert property (
    ovr_q[2] && $stable(ovr_q) && $stable(div_q) && div_q <= 3'h4 |-> div_code_o == div_q)
    else $error("divider field not followed");
  chk_div_ratio: assert property (
    div_code_o <= 3'h4 && div_ratio_o == (5'h01 << div_code_o))
    else $error("divider ratio wrong");
  chk_pump_off: assert property (
    $stable(ovr_q) && $stable(cp_q) |-> cp_enable_o == !(ovr_q[3] && cp_q == 2'h0))
    else $error("pump enable wrong");
  chk_cap_follow: assert property (
    $stable(ovr_q) && $stable(cap_q) |-> cap_ovr_o == ovr_q[7] && cap_count_o == cap_q)
    else $error("capacitor override wrong");
  chk_dac_follow: assert property (
    $stable(ovr_q) && $stable(lf_q) |-> lfdac_en_o == ovr_q[6] && lfdac_value_o == lf_q)
    else $error("filter dac override wrong");
  chk_clear_all: assert property (
    ovr_q == 8'h00 ##1 ovr_q == 8'h00 |-> !cap_ovr_o && !lfdac_en_o && cp_enable_o)
    else $error("cleared overrides still act");
  chk_mute_zero: assert property (
    tx_mute_o |-> !tx_bit_o)
    else $error("muted output not low");
  chk_prbs_unmuted: assert property (
    prbs_active_o |-> !tx_mute_o)
    else $error("running pattern muted");
endmodule

// ==== bench/ctrl_model.sv ====
`timescale 1ns/1ns
module ctrl_model (
  // clock
  input  wire logic       clk_i,
  // byte register port into the channel
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o
);
  // ----------------------------------------------------------------
  // controller side of the register port
  // ----------------------------------------------------------------
  logic [7:0] ovr_q;  // last byte put into the override register

  initial
  begin
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    ovr_q       = 8'h00;
  end

  // one access, strobe held over exactly one edge
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_i);
    #2;
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = w;
    reg_rd_o    = !w;
    ovr_q       = (w && a == 8'h09) ? d : ovr_q;
    @(posedge clk_i);
    #2;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, d, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(a, 8'h00, 1'b0);
  endtask

  // add override bits without dropping earlier ones
  task automatic ovr_set(input logic [7:0] b);
    wr(8'h09, ovr_q | b);
  endtask

  // let the vco run on its own
  task automatic free_run();
    wr(8'h14, 8'h80);  // force detect on
    ovr_set(8'h08);    // pump override
    wr(8'h1b, 8'h00);  // pump field zero
    ovr_set(8'h04);    // divider override, takes the divider field
    wr(8'h18, 8'h00);  // ratio 1
    ovr_set(8'h80);    // capacitor override
    wr(8'h08, 8'h08);  // capacitor count
    ovr_set(8'h40);    // filter dac on
    wr(8'h1f, 8'h12);  // filter dac value
  endtask

  // start the generator and put it on the output
  task automatic pattern_on(input logic [1:0] seq);
    wr(8'h1e, 8'h10);               // generator logic on
    wr(8'h30, 8'h00);               // hold generator clock
    wr(8'h30, {6'h00, seq});        // pick sequence
    wr(8'h30, {5'h01, 1'b0, seq});  // load generator clock
    wr(8'h0d, 8'h20);               // run generator clock
    ovr_set(8'h20);                 // take over the output
    wr(8'h1e, 8'h90);               // source code 4
  endtask
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/1ns
module tb_top
  import vco_prbs_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic       clk_i, sys_rst_i, sig_detect_i, cdr_locked_i, vco_qclk_i;
  logic       clk10m_i, vco_iclk_i, retimed_bit_i, raw_bit_i;
  logic [2:0] auto_div_code_i;
  wire  [7:0] reg_addr_i, reg_wdata_i;
  wire        reg_wr_i, reg_rd_i;
  reg_byte_t  reg_rdata_o;
  div_code_t  div_code_o;
  logic [4:0] div_ratio_o, cap_count_o, lfdac_value_o;
  logic       reg_rvalid_o, cap_ovr_o, lfdac_en_o, cp_enable_o, vco_track_o;
  logic       channel_en_o, tx_bit_o, tx_mute_o, prbs_active_o;
  int         miscompares = 0;
  int         checks      = 0;
  integer     seed        = 32'hee75;
  reg_byte_t  exp_q [$];                      // expected read bytes, oldest first
  reg_byte_t  d;                              // random write byte
  logic [3:0] src = 4'h0;                     // raw, retimed, iclk, slow clock
  reg_byte_t  ofs [9] = '{8'h08, 8'h09, 8'h0d, 8'h14, 8'h18, 8'h1b, 8'h1e, 8'h1f, 8'h30};
  mux_code_t  mux_of [4] = '{3'h0, 3'h1, 3'h2, 3'h5};

  assign {clk10m_i, vco_iclk_i, retimed_bit_i, raw_bit_i} = src;

  vco_override_prbs_control dut_u (.*);
  ctrl_model host_u (
    .clk_i       (clk_i),
    .reg_addr_o  (reg_addr_i),
    .reg_wdata_o (reg_wdata_i),
    .reg_wr_o    (reg_wr_i),
    .reg_rd_o    (reg_rd_i)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL %0t %s saw %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.rd(a);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  // collect output bits and test the shift recurrence
  task automatic prbs_chk(input int a, input int b);
    logic bits [100];
    int   ones;
    ones = 0;
    for (int n = 0; n < 100; n++)
    begin
      @(negedge clk_i);
      bits[n] = tx_bit_o;
      ones += (tx_bit_o === 1'b1) ? 1 : 0;
    end
    for (int n = a; n < 100; n++)
      check(8'(bits[n]), 8'(bits[n-a] ^ bits[n-b]), "pattern bit");
    check(8'(ones > ((a == 9) ? 20 : 8)), 8'h01, "pattern stuck");
  endtask

  // read answers are compared as they appear
  always @(negedge clk_i)
    if (reg_rvalid_o === 1'b1)
      check(reg_rdata_o, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx, "read");

  initial
  begin
    sys_rst_i       = 1'b1;
    sig_detect_i    = 1'b0;
    cdr_locked_i    = 1'b0;
    vco_qclk_i      = 1'b0;
    auto_div_code_i = 3'h0;
    cyc(8);
    sys_rst_i = 1'b0;
    foreach (ofs[i])
      rd(ofs[i], (ofs[i] == 8'h1e) ? 8'he0 : 8'h00);
    rd(8'h55, 8'h00);
    check(8'(channel_en_o), 8'h00, "idle channel off");
    $display("test reset values done");
    foreach (ofs[i])
    begin
      d = 8'($random(seed));
      host_u.wr(ofs[i], d);
      rd(ofs[i], d);
    end
    host_u.wr(8'h09, 8'h00);
    sys_rst_i = 1'b1;
    cyc(2);
    sys_rst_i = 1'b0;
    rd(8'h09, 8'h00);
    $display("test registers done");
    for (int c = 0; c < 5; c++)
    begin
      auto_div_code_i = 3'(c);
      cyc(3);
      check(8'(div_ratio_o), 8'h01 << c, "auto ratio");
    end
    host_u.wr(8'h09, 8'h04);
    for (int c = 0; c < 6; c++)
    begin
      auto_div_code_i = 3'({$random(seed)} % 5);
      host_u.wr(8'h18, {1'b0, 3'(c), 4'h0});
      cyc(3);
      check(8'(div_code_o), 8'((c < 5) ? c : 4), "override code");
    end
    host_u.wr(8'h09, 8'h00);
    $display("test divider done");
    host_u.free_run();
    cyc(4);
    check(8'({channel_en_o, cp_enable_o}), 8'h02, "forced free-run");
    check({cap_ovr_o, 2'h0, cap_count_o}, 8'h88, "cap override");
    check({lfdac_en_o, 2'h0, lfdac_value_o}, 8'h92, "dac override");
    for (int s = 0; s < 4; s += 2)
    begin
      host_u.pattern_on(2'(s));
      for (int i = 0; i < 40 && prbs_active_o !== 1'b1; i++)
        @(negedge clk_i);
      check(8'(prbs_active_o), 8'h01, "pattern started");
      if (prbs_active_o !== 1'b1)
        print_verdict();
      cyc(4);
      prbs_chk((s == 0) ? 9 : 31, (s == 0) ? 5 : 28);
    end
    rd(8'h09, 8'hec);
    host_u.wr(8'h0d, 8'h00);
    cyc(4);
    check(8'({tx_mute_o, prbs_active_o}), 8'h02, "stopped pattern");
    $display("test pattern done");
    for (int i = 0; i < 4; i++)
    begin
      host_u.wr(8'h1e, {mux_of[i], 5'h10});
      src = 4'(1 << i);
      cyc(5);
      check(8'({tx_mute_o, tx_bit_o}), 8'h01, "source passed");
      src = ~4'(1 << i);
      cyc(5);
      check(8'({tx_mute_o, tx_bit_o}), 8'h00, "source followed");
    end
    host_u.wr(8'h1e, 8'h71);
    vco_qclk_i = 1'b1;
    cyc(4);
    check(8'({tx_mute_o, tx_bit_o}), 8'h02, "quadrature gated");
    $display("test output select done");
    sig_detect_i = 1'b1;
    cdr_locked_i = 1'b1;
    host_u.wr(8'h09, 8'h00);
    host_u.wr(8'h14, 8'h00);
    cyc(6);
    check(8'({vco_track_o, tx_mute_o, cp_enable_o, cap_ovr_o}), 8'h0a, "normal");
    host_u.wr(8'h1e, 8'he0);
    host_u.ovr_set(8'h20);
    cyc(4);
    check(8'({vco_track_o, tx_mute_o}), 8'h03, "lock kept while muted");
    $display("test lock done");
    cyc(4);
    check(8'(exp_q.size()), 8'h00, "reads answered");
    print_verdict();
  end
endmodule

bind vco_override_prbs_control vco_prbs_checker chk_u (.*);
